// ---- rtl/usb_aux_map.svh ----
`ifndef USB_AUX_MAP_SVH
`define USB_AUX_MAP_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CTRL_ADDR 4'h0
`define STATUS_ADDR 4'h4
`define CTRL_RESET 8'h00
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_PU_POS 0
`define CTRL_PU_NEG 1
`define CTRL_SPK_LEFT 2
`define CTRL_SPK_RIGHT 3
`define CTRL_MIC 4
`define CTRL_UART 5
`define CTRL_EXT_SUPPLY 6
`define CTRL_REG_SEL 7
// ----------------------------------------
// Fixed levels and counts
// ----------------------------------------
`define NORMAL_REG_LEVEL 1'b0
`define RX_END_LIMIT 43
`define CMD_TX 2'h1
`define CMD_WR 2'h2
`define CMD_RD 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define FIFO_DEPTH 4
`endif

// ---- rtl/usb_aux_pkg.sv ----
package usb_aux_pkg;
  typedef logic [7:0] ulpi_byte_type;
  typedef logic [5:0] reg_addr_type;
  typedef enum logic [3:0] {
    st_idle, st_tx, st_wr_cmd, st_wr_data, st_wr_end, st_rd_cmd,
    st_rd_turn, st_rd_data, st_rx_turn, st_rx_data, st_back, st_hold
  } ulpi_state_type;
endpackage : usb_aux_pkg

// ---- rtl/aux_fifo.sv ----
module aux_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : aux_fifo

// ---- rtl/ulpi_reg_array.sv ----
module ulpi_reg_array (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire usb_aux_pkg::reg_addr_type waddr,
  input wire usb_aux_pkg::ulpi_byte_type wdata,
  input wire logic re,
  input wire usb_aux_pkg::reg_addr_type raddr,
  output usb_aux_pkg::ulpi_byte_type rdata_q
);
  import usb_aux_pkg::*;
  ulpi_byte_type mem_q [64];

  // Contents are not reset; only the read register is
  always_ff @(posedge aclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    if (!aresetn) begin
      rdata_q <= 8'h00;
    end else if (re) begin
      rdata_q <= mem_q[raddr];
    end
  end
endmodule : ulpi_reg_array

// ---- rtl/usb_aux_ctrl.sv ----
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`include "usb_aux_map.svh"
// Behaviour
// - No pin reflects the external supply drive bit; it is stored only.
// - In UART mode the regulator output takes the UART level select.
// - In UART mode line state never appears on data bits 0 and 1.
// - Pull-ups are off while chip reset is low, else follow own enables.
// - With chip reset high, core supply present and no audio enable set, both audio switches stay open.
// - Speaker and microphone enables reset to disabled.
// - Positive switch follows left; negative follows right or mic.
// - Chip reset low or core supply absent closes both switches.
// - Single-ended receivers are off while either switch is closed.
// - Receive end to bus release takes at most 43 clocks.
// - One protocol engine routes link traffic to transmitter or regs.
// - The link interface is eight data lines, clock and three controls.
// - Direction is high when sending or not ready, else low and listening.
// - After each direction change nobody drives and the bus is ignored.
module usb_aux_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ulpi_clk,
  input wire usb_aux_pkg::ulpi_byte_type ulpi_data_in,
  output usb_aux_pkg::ulpi_byte_type ulpi_data_out,
  output logic ulpi_data_oe,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  input wire logic ulpi_stp,
  input wire logic chip_reset_pin_n,
  input wire logic core_supply_present,
  input wire logic pll_locked,
  input wire logic [1:0] linestate_in,
  output logic pullup_pos_on,
  output logic pullup_neg_on,
  output logic switch_pos_closed,
  output logic switch_neg_closed,
  output logic se_rx_en,
  output logic regulator_level,
  output usb_aux_pkg::ulpi_byte_type tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire usb_aux_pkg::ulpi_byte_type rx_data,
  input wire logic rx_valid,
  output logic rx_ready
);
  import usb_aux_pkg::*;
  localparam int rx_end_max = `RX_END_LIMIT;

  function automatic ulpi_byte_type mask_uart(input ulpi_byte_type b,
                                              input logic uart);
    mask_uart = uart ? {b[7:2], 2'b00} : b;
  endfunction : mask_uart

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Inputs are sampled on the falling edge of the link clock, half a
  // period away from where the link changes them.
  logic [14:0] sync1_q, sync2_q;
  logic clk3_q, clk_s, stp_s, rst_s, sup_s, pll_s, tick;
  ulpi_byte_type din_s;
  logic [1:0] ls_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 15'h0000;
      sync2_q <= 15'h0000;
      clk3_q <= 1'b0;
    end else begin
      sync1_q <= {ulpi_clk, ulpi_stp, ulpi_data_in, chip_reset_pin_n,
                  core_supply_present, pll_locked, linestate_in};
      sync2_q <= sync1_q;
      clk3_q <= clk_s;
    end
  end
  assign {clk_s, stp_s, din_s, rst_s, sup_s, pll_s, ls_s} = sync2_q;
  assign tick = clk3_q && !clk_s;

  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [3:0] waddr_q, waddr_d;
  logic [7:0] wbyte_q, wbyte_d, ctrl_q, ctrl_d;
  logic wlane_q, wlane_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, status;

  assign awready = !aw_hold_q && !bvalid_q;
  assign wready = !w_hold_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    waddr_d = waddr_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    ctrl_d = ctrl_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (awvalid && awready) begin
      aw_hold_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_hold_d = 1'b1;
      wbyte_d = wdata[7:0];
      wlane_d = wstrb[0];
    end
    if (aw_hold_q && w_hold_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RESP_OKAY;
      // External supply bit is kept here only and reaches no pin
      if (waddr_q == `CTRL_ADDR) begin
        if (wlane_q) begin
          ctrl_d = wbyte_q;
        end
      end else if (waddr_q != `STATUS_ADDR) begin
        bresp_d = `RESP_SLVERR;
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (araddr == `CTRL_ADDR) begin
        rdata_d = {24'h00_0000, ctrl_q};
      end else if (araddr == `STATUS_ADDR) begin
        rdata_d = status;
      end else begin
        rresp_d = `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= 4'h0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      ctrl_q <= `CTRL_RESET;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      waddr_q <= waddr_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      ctrl_q <= ctrl_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Pull-ups, audio switches, regulator
  // ----------------------------------------
  logic uart;
  assign uart = ctrl_q[`CTRL_UART];
  assign pullup_pos_on = rst_s && ctrl_q[`CTRL_PU_POS];
  assign pullup_neg_on = rst_s && ctrl_q[`CTRL_PU_NEG];
  assign switch_pos_closed = !rst_s || !sup_s
                             || ctrl_q[`CTRL_SPK_LEFT];
  assign switch_neg_closed = !rst_s || !sup_s
                             || ctrl_q[`CTRL_SPK_RIGHT]
                             || ctrl_q[`CTRL_MIC];
  assign se_rx_en = !(switch_pos_closed || switch_neg_closed);
  assign regulator_level = uart ? ctrl_q[`CTRL_REG_SEL]
                                : `NORMAL_REG_LEVEL;
  assign status = {25'h000_0000, pullup_neg_on, pullup_pos_on, pll_s,
                   ulpi_dir, se_rx_en, switch_neg_closed, switch_pos_closed};

  // ----------------------------------------
  // Link protocol engine
  // ----------------------------------------
  ulpi_state_type state_q, state_d;
  logic dir_q, dir_d, nxt_q, nxt_d, oe_q, oe_d;
  ulpi_byte_type dout_q, dout_d, mem_rdata;
  reg_addr_type addr_q, addr_d;
  logic push, fifo_ready, mem_we, mem_re, rx_take;

  assign ulpi_dir = dir_q;
  assign ulpi_nxt = nxt_q;
  assign ulpi_data_oe = oe_q;
  assign ulpi_data_out = dout_q;
  assign rx_ready = rx_take;

  always_comb begin
    state_d = state_q;
    dir_d = dir_q;
    nxt_d = nxt_q;
    oe_d = oe_q;
    dout_d = dout_q;
    addr_d = addr_q;
    push = 1'b0;
    mem_we = 1'b0;
    mem_re = 1'b0;
    rx_take = 1'b0;
    if (tick) begin
      nxt_d = 1'b0;
      oe_d = 1'b0;
      if (!pll_s && state_q != st_hold) begin
        dir_d = 1'b1;
        state_d = st_hold;
      end else begin
        unique case (state_q)
          st_idle: begin
            if (din_s != 8'h00) begin
              addr_d = din_s[5:0];
              if (din_s[7:6] == `CMD_TX) begin
                state_d = st_tx;
                nxt_d = fifo_ready;
                // Command byte is the first byte the transmitter gets
                push = fifo_ready;
              end else if (din_s[7:6] == `CMD_WR) begin
                state_d = st_wr_cmd;
                nxt_d = 1'b1;
              end else if (din_s[7:6] == `CMD_RD) begin
                state_d = st_rd_cmd;
                nxt_d = 1'b1;
              end
            end else if (rx_valid) begin
              dir_d = 1'b1;
              state_d = st_rx_turn;
            end
          end
          st_tx: begin
            if (stp_s) begin
              state_d = st_idle;
            end else begin
              // Byte is taken at the tick that raises nxt; the link holds
              // it until its next edge. At most every other tick.
              nxt_d = fifo_ready && !nxt_q;
              push = nxt_d;
            end
          end
          st_wr_cmd: begin
            nxt_d = 1'b1;
            state_d = st_wr_data;
          end
          st_wr_data: begin
            mem_we = 1'b1;
            state_d = st_wr_end;
          end
          st_wr_end: state_d = st_idle;
          st_rd_cmd: begin
            mem_re = 1'b1;
            dir_d = 1'b1;
            state_d = st_rd_turn;
          end
          st_rd_turn: begin
            oe_d = 1'b1;
            dout_d = mask_uart(mem_rdata, uart);
            state_d = st_rd_data;
          end
          st_rd_data: begin
            dir_d = 1'b0;
            state_d = st_back;
          end
          st_rx_turn: begin
            oe_d = 1'b1;
            dout_d = mask_uart({6'h00, ls_s}, uart);
            state_d = st_rx_data;
          end
          st_rx_data: begin
            if (rx_valid) begin
              oe_d = 1'b1;
              nxt_d = 1'b1;
              rx_take = 1'b1;
              dout_d = mask_uart(rx_data, uart);
            end else begin
              dir_d = 1'b0;
              state_d = st_back;
            end
          end
          st_back: state_d = st_idle;
          st_hold: begin
            if (pll_s) begin
              dir_d = 1'b0;
              state_d = st_back;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= st_idle;
      dir_q <= 1'b0;
      nxt_q <= 1'b0;
      oe_q <= 1'b0;
      dout_q <= 8'h00;
      addr_q <= 6'h00;
    end else begin
      state_q <= state_d;
      dir_q <= dir_d;
      nxt_q <= nxt_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      addr_q <= addr_d;
    end
  end

  aux_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) tx_fifo (
    .aclk(aclk), .aresetn(aresetn),
    .in_valid(push), .in_ready(fifo_ready), .in_data(din_s),
    .out_valid(tx_valid), .out_ready(tx_ready), .out_data(tx_data)
  );

  ulpi_reg_array regs (
    .aclk(aclk), .aresetn(aresetn),
    .we(mem_we), .waddr(addr_q), .wdata(din_s),
    .re(mem_re), .raddr(addr_q), .rdata_q(mem_rdata)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  pullup_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pullup_pos_on || pullup_neg_on) |-> rst_s)
    else $error("pull-up on during chip reset");
  switch_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rst_s || !sup_s) |-> (switch_pos_closed && switch_neg_closed))
    else $error("switch open while reset or unpowered");
  switch_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rst_s && sup_s && ctrl_q[4:2] == 3'h0)
      |-> !(switch_pos_closed || switch_neg_closed))
    else $error("switch closed with no enable");
  switch_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rst_s && sup_s) |-> (switch_pos_closed == ctrl_q[`CTRL_SPK_LEFT]))
    else $error("positive switch not following left enable");
  se_rx_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (switch_pos_closed || switch_neg_closed) |-> !se_rx_en)
    else $error("receivers on with switch closed");
  uart_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uart |-> regulator_level == ctrl_q[`CTRL_REG_SEL])
    else $error("regulator level wrong in uart mode");
  uart_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (uart && $past(uart) && ulpi_data_oe && $changed(ulpi_data_out))
      |-> ulpi_data_out[1:0] == 2'b00)
    else $error("line state shown in uart mode");
  turnaround_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(ulpi_dir) |-> !ulpi_data_oe)
    else $error("bus driven in turnaround cycle");
  rx_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == st_rx_data && tick && !rx_valid && pll_s)
      |-> ##[1:rx_end_max] !ulpi_dir)
    else $error("bus not released after receive end");
  not_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && !pll_s) |=> ulpi_dir)
    else $error("direction low while not ready");
  route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    push |-> (fifo_ready && nxt_d && !ulpi_dir && !mem_we))
    else $error("transmit byte misrouted or lost");
endmodule : usb_aux_ctrl

// ---- test/ulpi_link_model.sv ----
// ----------------------------------------
// Link controller on the far side of the 12-signal bus
// ----------------------------------------
// data bus, clock, direction, next and stop are the whole interface
module ulpi_link_model (
  input wire logic ulpi_clk,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire usb_aux_pkg::ulpi_byte_type dev_data,
  input wire logic dev_oe,
  output usb_aux_pkg::ulpi_byte_type bus,
  output logic ulpi_stp
);
  timeunit 1ns;
  timeprecision 100ps;
  import usb_aux_pkg::*;
  ulpi_byte_type drv = 8'h00;
  ulpi_byte_type last = 8'h00;
  ulpi_byte_type rxcmd = 8'h00;
  ulpi_byte_type rx_q[$];
  logic drv_on = 1'b0;
  logic dir_was = 1'b0;
  logic dir_was2 = 1'b0;
  // The link, not the device, owns the external supply switch
  logic ext_supply_on = 1'b0;
  initial ulpi_stp = 1'b0;
  // Idle link drives 00; in turnaround the bus shows the inverse of its
  // last byte so a stale byte is never mistaken for data
  assign bus = dev_oe ? dev_data :
               (ulpi_dir || dir_was || dir_was2) ? ~last :
               drv_on ? drv : 8'h00;
  always @(posedge ulpi_clk) begin
    last <= bus;
    dir_was <= ulpi_dir;
    dir_was2 <= dir_was;
    if (ulpi_dir && dev_oe) begin
      if (ulpi_nxt) rx_q.push_back(bus);
      else rxcmd <= bus;
    end
  end
  // Hold one byte until the device signals that it took it
  task automatic put(input ulpi_byte_type b);
    drv <= b;
    drv_on <= 1'b1;
    do @(posedge ulpi_clk); while (!ulpi_nxt);
  endtask : put
  task automatic idle_wait();
    @(posedge ulpi_clk);
    while (ulpi_dir || dir_was) @(posedge ulpi_clk);
  endtask : idle_wait
  task automatic send(input ulpi_byte_type b[$]);
    idle_wait();
    foreach (b[i]) put(b[i]);
    ulpi_stp <= 1'b1;
    @(posedge ulpi_clk);
    ulpi_stp <= 1'b0;
    drv_on <= 1'b0;
  endtask : send
  task automatic read(input logic [5:0] a, output ulpi_byte_type d);
    idle_wait();
    put({2'b11, a});
    drv_on <= 1'b0;
    do @(posedge ulpi_clk); while (!(ulpi_dir && dev_oe));
    d = bus;
  endtask : read
endmodule : ulpi_link_model

// ---- test/usb_aux_ctrl_bench.sv ----
`include "usb_aux_map.svh"
module usb_aux_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import usb_aux_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ulpi_clk, ulpi_oe, ulpi_dir;
  logic ulpi_nxt, ulpi_stp, chip_reset_pin_n, core_supply_present;
  logic pll_locked, pullup_pos_on, pullup_neg_on, switch_pos_closed;
  logic switch_neg_closed, se_rx_en, regulator_level;
  logic tx_valid, tx_ready, rx_valid, rx_ready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, linestate_in;
  ulpi_byte_type bus, dout, tx_data, rx_data, got;
  ulpi_byte_type txq[$];
  int compares, miscompares, cyc;
  logic [7:0] cv [8] = '{8'h03, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80, 8'h20,
                         8'hA0};
  logic [5:0] pe [8] = '{6'h19, 6'h02, 6'h04, 6'h04, 6'h01, 6'h01, 6'h01,
                         6'h21};
  logic [7:0] txe [6] = '{8'h41, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};

  usb_aux_ctrl usb_aux_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ulpi_clk(ulpi_clk),
    .ulpi_data_in(bus), .ulpi_data_out(dout), .ulpi_data_oe(ulpi_oe),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp),
    .chip_reset_pin_n(chip_reset_pin_n),
    .core_supply_present(core_supply_present), .pll_locked(pll_locked),
    .linestate_in(linestate_in), .pullup_pos_on(pullup_pos_on),
    .pullup_neg_on(pullup_neg_on), .switch_pos_closed(switch_pos_closed),
    .switch_neg_closed(switch_neg_closed), .se_rx_en(se_rx_en),
    .regulator_level(regulator_level), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready)
  );
  ulpi_link_model ulpi_link_model_inst (
    .ulpi_clk(ulpi_clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .dev_data(dout), .dev_oe(ulpi_oe), .bus(bus), .ulpi_stp(ulpi_stp)
  );

  // ----------------------------------------
  // Clocks, timeout and transmit capture
  // ----------------------------------------
  always #4 aclk = ~aclk;
  always #62.5 ulpi_clk = ~ulpi_clk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end
  always @(posedge aclk) if (tx_valid && tx_ready) txq.push_back(tx_data);

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Response readies stay high for the whole run, which the bus allows
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, er);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rresp, er);
    if (er == `RESP_OKAY) chk(rdata, ed);
  endtask : axi_rd
  // Pins cross a two-flop synchroniser, so allow a few clocks first
  task automatic pins(input logic [5:0] e);
    repeat (4) @(posedge aclk);
    chk({regulator_level, pullup_neg_on, pullup_pos_on, switch_neg_closed,
         switch_pos_closed, se_rx_en}, {26'h0, e});
  endtask : pins
  task automatic rx_send(input ulpi_byte_type b, input ulpi_byte_type ec,
                         input ulpi_byte_type eb);
    int n;
    rx_data <= b;
    rx_valid <= 1'b1;
    do @(posedge aclk); while (!rx_ready);
    rx_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (ulpi_dir && n < 43);
    chk(ulpi_dir, 1'b0);
    repeat (40) @(posedge aclk);
    chk(ulpi_link_model_inst.rxcmd, ec);
    chk(ulpi_link_model_inst.rx_q.pop_front(), eb);
  endtask : rx_send

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    ulpi_clk = 1'b0;
    {aresetn, awvalid, wvalid, arvalid, chip_reset_pin_n} = '0;
    {tx_ready, rx_valid, cyc, compares, miscompares} = '0;
    {awaddr, araddr, wdata, rx_data, linestate_in} = '0;
    {bready, rready, core_supply_present, pll_locked} = 4'hF;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CTRL_ADDR, 32'h0, `RESP_OKAY);
    pins(6'h06);
    chip_reset_pin_n <= 1'b1;
    foreach (cv[i]) begin
      axi_wr(`CTRL_ADDR, {24'h0, cv[i]}, `RESP_OKAY);
      pins(pe[i]);
      axi_rd(`CTRL_ADDR, {24'h0, cv[i]}, `RESP_OKAY);
    end
    axi_wr(`CTRL_ADDR, 32'h3, `RESP_OKAY);
    axi_rd(`STATUS_ADDR, 32'h74, `RESP_OKAY);
    core_supply_present <= 1'b0;
    pins(6'h1E);
    core_supply_present <= 1'b1;
    chip_reset_pin_n <= 1'b0;
    pins(6'h06);
    chip_reset_pin_n <= 1'b1;
    axi_wr(4'h8, 32'hFF, `RESP_SLVERR);
    axi_rd(4'hC, 32'h0, `RESP_SLVERR);
    axi_wr(`STATUS_ADDR, 32'hFF, `RESP_OKAY);
    axi_rd(`CTRL_ADDR, 32'h3, `RESP_OKAY);
    axi_wr(`CTRL_ADDR, 32'h0, `RESP_OKAY);
    ulpi_link_model_inst.send({8'h8A, 8'h5A});
    ulpi_link_model_inst.send({8'h95, 8'hA5});
    ulpi_link_model_inst.read(6'h0A, got);
    chk(got, 8'h5A);
    ulpi_link_model_inst.read(6'h15, got);
    chk(got, 8'hA5);
    // Transmitter stalls so the four-word buffer fills and throttles next
    fork
      ulpi_link_model_inst.send({8'h41, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
      begin
        repeat (200) @(posedge aclk);
        tx_ready <= 1'b1;
      end
    join
    repeat (20) @(posedge aclk);
    chk(txq.size(), 6);
    foreach (txe[i]) chk(txq[i], txe[i]);
    linestate_in <= 2'b11;
    rx_send(8'hA7, 8'h03, 8'hA7);
    axi_wr(`CTRL_ADDR, 32'h20, `RESP_OKAY);
    rx_send(8'hA7, 8'h00, 8'hA4);
    pll_locked <= 1'b0;
    repeat (60) @(posedge aclk);
    chk({ulpi_dir, ulpi_oe}, 2'b10);
    pll_locked <= 1'b1;
    repeat (60) @(posedge aclk);
    chk(ulpi_dir, 1'b0);
    end_sim();
  end
endmodule : usb_aux_ctrl_bench
